// *** rtl/tmr16_timer.sv ***
/*
  16-bit timer/event counter with prescaler mode registers, interval timer,
  programmable pulse output and pulse width measurement on two inputs.
  Assumes inputs synchronous to clk_sys_i; mode, run and compare values
  come from plain ports driven by the surrounding control logic.
*/
// Behaviour
// - Reset clears both prescaler registers to zero
// - Prescaler registers accept byte-wide writes
// - Bits 7:6 pick second input valid edge
// - Bits 5:4 pick first input valid edge
// - Three-bit code picks divider or input edge
// - Code is two low bits plus extension bit
// - Post-reset high pin gives one early rise
// - Interval match clears counter, raises compare request
// - Pulse mode: period compare zero, width one
// - Measure widths free-running or restart on edge
// - First input edge captures counter, raises request, unless it is the count clock
// - Edge accepted after two equal count-clock samples, fxx/2 samples when edge-clocked
module tmr16_timer
  import tmr16_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input wire logic clk_sys_i, // System clock, 50 MHz
  input wire logic rst_i, // Synchronous reset, active high
  input wire logic [31:0] bus_addr_i, // Register byte address
  input wire logic [7:0] bus_wdata_i, // Write byte
  input wire logic bus_wr_i, // Write strobe
  input wire logic bus_rd_i, // Read strobe
  input wire logic timer_run_i, // Counter enabled
  input wire tmr16_mode_t mode_i, // Operating mode
  input wire logic [CNT_W-1:0] compare_zero_i, // Compare value zero
  input wire logic [CNT_W-1:0] compare_one_i, // Compare value one
  input wire logic first_timer_input_i, // First timer input pin
  input wire logic second_timer_input_i, // Second timer input pin
  output logic [7:0] bus_rdata_o, // Read byte, registered
  output logic [CNT_W-1:0] timer_counter_value_o, // Counter value
  output logic [CNT_W-1:0] capture_zero_o, // Capture from second input
  output logic [CNT_W-1:0] capture_one_o, // Capture from first input
  output logic compare_zero_irq_o, // Compare/capture zero request, pulse
  output logic capture_one_irq_o, // Capture one request, pulse
  output logic timer_output_pin_o // Pulse output pin
);

  // Accept an edge of the kind selected by a two-bit code
  function automatic logic edge_ok(input logic [1:0] sel, input logic rise, input logic fall);
    case (sel)
      EDGE_FALL: edge_ok = fall;
      EDGE_RISE: edge_ok = rise;
      EDGE_BOTH: edge_ok = rise | fall;
      default: edge_ok = 1'b0; // Prohibited code gives no edge
    endcase
  endfunction

  logic [7:0] prescale_edge_reg;
  logic [7:0] prescale_ext_reg;
  logic [7:0] div_cnt;
  logic [2:0] clk_sel;
  logic pre_tick;
  logic samp_tick;
  logic cnt_tick;
  logic armed;
  logic [1:0] pins;
  logic [1:0] samp1;
  logic [1:0] level;
  logic [1:0] rise;
  logic [1:0] fall;
  logic [1:0] edge_hit;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic hit_zero;

  assign pins = {second_timer_input_i, first_timer_input_i};

  // Byte-wide register writes, fixed-zero bits masked
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      prescale_edge_reg <= PRESCALE_RESET;
      prescale_ext_reg <= PRESCALE_RESET;
    end else if (bus_wr_i) begin
      if (bus_addr_i == PRESCALE_EDGE_ADDR) begin
        prescale_edge_reg <= bus_wdata_i & EDGE_REG_MASK;
      end
      if (bus_addr_i == PRESCALE_EXT_ADDR) begin
        prescale_ext_reg <= bus_wdata_i & EXT_REG_MASK;
      end
    end
  end

  // Registered read; unmapped addresses read as zero
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      bus_rdata_o <= 8'h00;
    end else if (bus_rd_i) begin
      if (bus_addr_i == PRESCALE_EDGE_ADDR) begin
        bus_rdata_o <= prescale_edge_reg;
      end else if (bus_addr_i == PRESCALE_EXT_ADDR) begin
        bus_rdata_o <= prescale_ext_reg;
      end else begin
        bus_rdata_o <= 8'h00;
      end
    end
  end

  // Clock select code assembled from both registers
  assign clk_sel = {prescale_ext_reg[CLOCK_SEL_BIT2],
                    prescale_edge_reg[CLOCK_SEL_HI:CLOCK_SEL_LO]};

  // Free-running divider; runs always so ticks stay phase-stable
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      div_cnt <= 8'h00;
    end else begin
      div_cnt <= div_cnt + 8'h01;
    end
  end

  // Prescaled tick per clock code; prohibited code never ticks
  always_comb begin
    case (clk_sel)
      CLK_DIV2: pre_tick = &div_cnt[0:0];
      CLK_DIV4: pre_tick = &div_cnt[1:0];
      CLK_DIV16: pre_tick = &div_cnt[3:0];
      CLK_EDGE: pre_tick = 1'b0;
      CLK_DIV32: pre_tick = &div_cnt[4:0];
      CLK_DIV128: pre_tick = &div_cnt[6:0];
      CLK_DIV256: pre_tick = &div_cnt[7:0];
      default: pre_tick = 1'b0;
    endcase
  end

  // Inputs are sampled at the count clock; edge clocking samples at fxx/2
  assign samp_tick = (clk_sel == CLK_EDGE) ? div_cnt[0] : pre_tick;

  // Remember the first enable so a stopped timer tracks the pins
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      armed <= 1'b0;
    end else if (timer_run_i) begin
      armed <= 1'b1;
    end
  end

  // Two-sample noise filter per input
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_filter
      always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
          samp1[gi] <= 1'b0;
          level[gi] <= 1'b0; // Low after reset: a high pin shows a rise
        end else if (!timer_run_i && armed) begin
          // Follow the pin while stopped so re-enable sees no stale edge
          samp1[gi] <= pins[gi];
          level[gi] <= pins[gi];
        end else if (timer_run_i && samp_tick) begin
          samp1[gi] <= pins[gi];
          if (pins[gi] == samp1[gi] && pins[gi] != level[gi]) begin
            level[gi] <= pins[gi];
          end
        end
      end
      assign rise[gi] = timer_run_i && samp_tick && pins[gi] && samp1[gi] && !level[gi];
      assign fall[gi] = timer_run_i && samp_tick && !pins[gi] && !samp1[gi] && level[gi];
    end
  endgenerate

  assign edge_hit[0] = edge_ok(prescale_edge_reg[FIRST_EDGE_HI:FIRST_EDGE_LO],
                               rise[0], fall[0]);
  assign edge_hit[1] = edge_ok(prescale_edge_reg[SECOND_EDGE_HI:SECOND_EDGE_LO],
                               rise[1], fall[1]);

  // Count tick: prescaled clock or first input valid edge
  assign cnt_tick = timer_run_i && ((clk_sel == CLK_EDGE) ? edge_hit[0] : pre_tick);
  assign hit_zero = (cnt == compare_zero_i);

  // Next counter value by mode; edge-clocked mode relies on no restart
  always_comb begin
    next_cnt = cnt;
    if (!timer_run_i) begin
      next_cnt = '0; // Stopped timer is held cleared
    end else begin
      case (mode_i)
        TMR16_INTERVAL, TMR16_PULSE: begin
          if (cnt_tick) begin
            next_cnt = hit_zero ? '0 : cnt + 1'b1;
          end
        end
        TMR16_FREE_CAPTURE: begin
          if (cnt_tick) begin
            next_cnt = cnt + 1'b1; // Wraps from all ones
          end
        end
        TMR16_RESTART_CAPTURE: begin
          if (edge_hit[0] && clk_sel != CLK_EDGE) begin
            next_cnt = '0;
          end else if (cnt_tick) begin
            next_cnt = cnt + 1'b1;
          end
        end
        default: next_cnt = cnt;
      endcase
    end
  end

  // Counter register
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end
  assign timer_counter_value_o = cnt;

  // Captures and interrupt request pulses
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      capture_zero_o <= '0;
      capture_one_o <= '0;
      compare_zero_irq_o <= 1'b0;
      capture_one_irq_o <= 1'b0;
    end else begin
      compare_zero_irq_o <= 1'b0;
      capture_one_irq_o <= 1'b0;
      if (timer_run_i) begin
        case (mode_i)
          TMR16_INTERVAL, TMR16_PULSE: begin
            compare_zero_irq_o <= cnt_tick && hit_zero;
          end
          TMR16_FREE_CAPTURE, TMR16_RESTART_CAPTURE: begin
            // Edge clock is not a capture trigger
            if (edge_hit[0] && clk_sel != CLK_EDGE) begin
              capture_one_o <= cnt;
              capture_one_irq_o <= 1'b1;
            end
            if (edge_hit[1] && mode_i == TMR16_FREE_CAPTURE) begin
              capture_zero_o <= cnt;
              compare_zero_irq_o <= 1'b1;
            end
          end
          default: compare_zero_irq_o <= 1'b0;
        endcase
      end
    end
  end

  // Pulse output: high from zero until compare one; low when not in pulse mode
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      timer_output_pin_o <= 1'b0;
    end else begin
      timer_output_pin_o <= timer_run_i && mode_i == TMR16_PULSE
                            && (cnt < compare_one_i);
    end
  end

  a_reset_clears: assert property (@(posedge clk_sys_i)
    rst_i |=> prescale_edge_reg == 8'h00 && prescale_ext_reg == 8'h00)
    else $error("prescaler registers not cleared by reset");

  a_byte_write: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    bus_wr_i && bus_addr_i == PRESCALE_EDGE_ADDR
    |=> prescale_edge_reg == ($past(bus_wdata_i) & EDGE_REG_MASK))
    else $error("edge register write lost");

  a_no_bad_edge: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    prescale_edge_reg[FIRST_EDGE_HI:FIRST_EDGE_LO] == 2'h2 |-> !edge_hit[0])
    else $error("prohibited edge code produced an edge");

  a_clock_bad: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    clk_sel == 3'h7 |-> !cnt_tick)
    else $error("prohibited clock code produced a tick");

  a_interval_clear: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    timer_run_i && mode_i == TMR16_INTERVAL && cnt_tick && hit_zero
    |=> cnt == '0 && compare_zero_irq_o)
    else $error("interval match did not clear and request");

  a_pulse_level: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    timer_run_i && mode_i == TMR16_PULSE
    |=> timer_output_pin_o == ($past(cnt) < $past(compare_one_i)))
    else $error("pulse output level wrong");

  a_restart_zero: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    timer_run_i && mode_i == TMR16_RESTART_CAPTURE && edge_hit[0] && clk_sel != CLK_EDGE
    |=> cnt == '0 && capture_one_irq_o)
    else $error("restart edge did not clear counter");

  a_capture_one: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    timer_run_i && mode_i == TMR16_FREE_CAPTURE && edge_hit[0] && clk_sel != CLK_EDGE
    |=> capture_one_o == $past(cnt) && capture_one_irq_o)
    else $error("first input edge did not capture");

  a_filter_two: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    timer_run_i && $rose(level[0]) |-> $past(samp1[0]) && $past(pins[0]))
    else $error("edge accepted without two equal samples");

  a_count_step: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    timer_run_i && mode_i == TMR16_FREE_CAPTURE && cnt_tick && $stable(timer_run_i)
    |=> cnt == CNT_W'($past(cnt) + 1'b1))
    else $error("counter did not advance by one");

endmodule

// *** shared/tmr16_pkg.sv ***
/*
  Constants and types shared by the 16-bit timer unit: register addresses,
  field positions, reset values, clock select and edge codes, timer modes.
  Assumes a single system clock domain and byte-wide register accesses.
*/
package tmr16_pkg;

  // Register byte addresses on the internal bus
  localparam logic [31:0] PRESCALE_EDGE_ADDR = 32'hFFFF_F216;
  localparam logic [31:0] PRESCALE_EXT_ADDR = 32'hFFFF_F218;

  // Values after reset
  localparam logic [7:0] PRESCALE_RESET = 8'h00;

  // Writable bits of each register; fixed-zero bits are masked
  localparam logic [7:0] EDGE_REG_MASK = 8'hF3;
  localparam logic [7:0] EXT_REG_MASK = 8'h01;

  // Field positions in the edge/prescale register
  localparam int SECOND_EDGE_HI = 7;
  localparam int SECOND_EDGE_LO = 6;
  localparam int FIRST_EDGE_HI = 5;
  localparam int FIRST_EDGE_LO = 4;
  localparam int CLOCK_SEL_HI = 1;
  localparam int CLOCK_SEL_LO = 0;
  // Field position in the extension register
  localparam int CLOCK_SEL_BIT2 = 0;

  // Valid edge codes
  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  // Count clock codes
  localparam logic [2:0] CLK_DIV2 = 3'h0;
  localparam logic [2:0] CLK_DIV4 = 3'h1;
  localparam logic [2:0] CLK_DIV16 = 3'h2;
  localparam logic [2:0] CLK_EDGE = 3'h3;
  localparam logic [2:0] CLK_DIV32 = 3'h4;
  localparam logic [2:0] CLK_DIV128 = 3'h5;
  localparam logic [2:0] CLK_DIV256 = 3'h6;

  // Operating modes of the counter
  typedef enum logic [1:0] {
    TMR16_INTERVAL,
    TMR16_PULSE,
    TMR16_FREE_CAPTURE,
    TMR16_RESTART_CAPTURE
  } tmr16_mode_t;

endpackage

// *** testbench/tmr16_pin_src.sv ***
/*
  Signal source for the two timer input pins.
  Assumes the bench sets the wanted levels; pins follow one edge later.
*/
module tmr16_pin_src (
  input wire logic clk_i, // Bench clock
  input wire logic [1:0] level_i, // Wanted pin levels
  output logic first_o, // First timer input pin
  output logic second_o // Second timer input pin
);
  timeunit 1ns;
  timeprecision 100ps;
  // Pins move just after an edge, as a synchronous source would
  initial {second_o, first_o} = 2'b00;
  always @(posedge clk_i) begin
    {second_o, first_o} <= #2 level_i;
  end
endmodule

// *** testbench/timer16_prescaler_modes_test.sv ***
/*
  Self-checking bench for the 16-bit timer: registers, dividers, pulse
  output, edge capture and noise filter. Assumes one 50 MHz clock.
*/
module timer16_prescaler_modes_test;
  timeunit 1ns;
  timeprecision 100ps;
  import tmr16_pkg::*;
  logic clk_sys_i = 0, rst_i = 1, wr = 0, rd = 0, run = 0, p1, p2, irq0, irq1, pin;
  logic [31:0] addr = 0, seed = 32'he0d5;
  logic [7:0] wd = 0, rdata;
  logic [15:0] cr0 = 0, cr1 = 0, cnt, c0, c1;
  logic [1:0] level = 2'b01;
  tmr16_mode_t mode = TMR16_INTERVAL;
  int fails = 0, samples_checked = 0, cyc = 0, hi, q0[$], q1[$];
  logic [15:0] k0[$], k1[$];
  int divs[6] = '{2, 4, 16, 32, 128, 256};
  logic [2:0] codes[6] = '{CLK_DIV2, CLK_DIV4, CLK_DIV16, CLK_DIV32, CLK_DIV128, CLK_DIV256};
  int nexp[4] = '{1, 1, 0, 2};
  tmr16_timer uut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .bus_addr_i(addr),
    .bus_wdata_i(wd), .bus_wr_i(wr), .bus_rd_i(rd), .timer_run_i(run), .mode_i(mode),
    .compare_zero_i(cr0), .compare_one_i(cr1), .first_timer_input_i(p1),
    .second_timer_input_i(p2), .bus_rdata_o(rdata), .timer_counter_value_o(cnt),
    .capture_zero_o(c0), .capture_one_o(c1), .compare_zero_irq_o(irq0),
    .capture_one_irq_o(irq1), .timer_output_pin_o(pin));
  tmr16_pin_src src (.clk_i(clk_sys_i), .level_i(level), .first_o(p1), .second_o(p2));
  initial begin
    forever #10 clk_sys_i = ~clk_sys_i;
  end
  // Model side: log every request pulse with its cycle and capture
  always @(posedge clk_sys_i) begin
    cyc++;
    if (irq0 === 1'b1) begin q0.push_back(cyc); k0.push_back(c0); end
    if (irq1 === 1'b1) begin q1.push_back(cyc); k1.push_back(c1); end
  end
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
    #2;
  endtask
  task automatic results();
    if (fails == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (e !== g) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Strobes drop for a full cycle so back-to-back calls never collide
  task automatic wr_reg(input logic [31:0] a, input logic [7:0] d);
    addr = a; wd = d; wr = 1;
    tick(1);
    wr = 0;
    tick(1);
  endtask
  task automatic rd_chk(input logic [31:0] a, input logic [7:0] e, input string nm);
    addr = a; rd = 1;
    tick(1);
    rd = 0;
    chk(nm, {24'h0, e}, {24'h0, rdata});
    tick(1);
  endtask
  // Timer is stopped before any prescaler write
  task automatic setup(input logic [7:0] eb, input logic [2:0] code);
    run = 0;
    tick(4);
    wr_reg(PRESCALE_EDGE_ADDR, eb | {6'h00, code[1:0]});
    wr_reg(PRESCALE_EXT_ADDR, {7'h00, code[2]});
    q0.delete(); q1.delete(); k0.delete(); k1.delete();
  endtask
  task automatic wait_q0(input int n);
    for (int i = 0; i < 5000 && q0.size() < n; i++) tick(1);
    if (q0.size() < n) begin
      fails++;
      results();
    end
  endtask
  initial begin
    tick(2);
    rst_i = 0;
    rd_chk(PRESCALE_EDGE_ADDR, 8'h00, "edge reg reset");
    rd_chk(PRESCALE_EXT_ADDR, 8'h00, "ext reg reset");
    // Pin high since reset: one early rise, none after a restart
    mode = TMR16_FREE_CAPTURE;
    setup(8'h10, CLK_DIV2);
    run = 1;
    tick(30);
    chk("early rise", 1, q1.size());
    run = 0;
    tick(10);
    run = 1;
    tick(30);
    chk("re-enable rise", 1, q1.size());
    run = 0; level = 0;
    wr_reg(PRESCALE_EDGE_ADDR, 8'h5D);
    rd_chk(PRESCALE_EDGE_ADDR, 8'h51, "edge reg");
    wr_reg(PRESCALE_EXT_ADDR, 8'hFF);
    rd_chk(PRESCALE_EXT_ADDR, 8'h01, "ext reg");
    rd_chk(32'hFFFF_F220, 8'h00, "unmapped");
    // Every divider code with a random compare value
    mode = TMR16_INTERVAL;
    for (int k = 0; k < 6; k++) begin
      cr0 = 16'(xs() % 4 + 1);
      setup(8'h00, codes[k]);
      run = 1;
      wait_q0(3);
      chk("interval", (cr0 + 1) * divs[k], q0[2] - q0[1]);
    end
    // Prohibited clock code never ticks the counter
    cr0 = 16'h0001;
    setup(8'h00, 3'h7);
    run = 1;
    tick(40);
    chk("bad clock irqs", 0, q0.size());
    chk("bad clock count", 0, {16'h0, cnt});
    // Edge as count clock, both edges: 16 edges over period 4
    cr0 = 16'h0003;
    setup(8'h30, CLK_EDGE);
    run = 1;
    for (int i = 0; i < 16; i++) begin level = 2'(i % 2 == 0); tick(10); end
    tick(20);
    chk("edge clock irqs", 4, q0.size());
    chk("edge clock no capture", 0, q1.size());
    mode = TMR16_PULSE; cr0 = 16'h0009; cr1 = 16'h0004; level = 0;
    setup(8'h00, CLK_DIV2);
    run = 1;
    tick(40);
    hi = 0;
    for (int i = 0; i < 80; i++) begin hi += (pin === 1'b1); tick(1); end
    chk("pulse high", 32, hi);
    // Every edge code on both inputs, rise then fall 200 cycles apart
    mode = TMR16_FREE_CAPTURE;
    for (int e = 0; e < 4; e++) begin
      for (int s = 0; s < 2; s++) begin
        setup(8'(e << (s ? 6 : 4)), CLK_DIV2);
        run = 1;
        tick(10);
        // Quiet pins: twenty cycles at fxx/2 are exactly ten ticks
        hi = int'(cnt);
        tick(20);
        chk("count step", 10, 32'(cnt - 16'(hi)));
        level = 2'(1 << s);
        tick(200);
        level = 0;
        tick(200);
        chk("edge irqs", nexp[e], s ? q0.size() : q1.size());
        if (e == 3 && s == 0) chk("gap one", 100, 32'(k1[1] - k1[0]));
        if (e == 3 && s == 1) chk("gap zero", 100, 32'(k0[1] - k0[0]));
      end
    end
    // Short pulse is rejected at /16, a long level is taken once
    setup(8'h10, CLK_DIV16);
    run = 1;
    tick(40);
    level = 1;
    tick(3);
    level = 0;
    tick(60);
    chk("noise", 0, q1.size());
    level = 1;
    tick(100);
    chk("filtered edge", 1, q1.size());
    // Restart mode: equal captures for equal rise spacing
    mode = TMR16_RESTART_CAPTURE;
    level = 0;
    setup(8'h10, CLK_DIV2);
    run = 1;
    for (int i = 0; i < 6; i++) begin level = 2'(i % 2 == 0); tick(100); end
    chk("restart count", 3, q1.size());
    if (q1.size() == 3) chk("restart capture", {16'h0, k1[1]}, {16'h0, k1[2]});
    results();
  end
endmodule
